//--- src/jtag_pkg.sv
// Shared constants and types for the TAP debug channel.
// Assumes both ends are compiled against this package.
package jtag_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // Break point resource layouts
  typedef enum logic [2:0] {
    BP_4PROG, BP_3PROG_1DATA, BP_2PROG_2DATA, BP_2PROG_PRANGE, BP_2PROG_DRANGE
  } bp_mode_t;

  typedef enum logic [1:0] {KIND_RESET, KIND_IR, KIND_DR} host_kind_t;
  typedef enum logic [1:0] {H_IDLE, H_PRE, H_SHIFT, H_POST} host_state_t;

  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] OP_DEBUG0 = 4'h8;
  localparam logic [IR_W-1:0] OP_DEBUG1 = 4'h9;
  localparam logic [IR_W-1:0] OP_DEBUG2 = 4'hA;
  localparam logic [IR_W-1:0] OP_DEBUG3 = 4'hB;

  localparam int MBX_W = 8;
  localparam int DR_MAX = 9;
  localparam logic [3:0] LEN_MBX = 4'h9;
  localparam logic [3:0] LEN_BP = 4'h3;
  localparam logic [3:0] LEN_CMD = 4'h8;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam int MBX_CLR_BIT = 0;
  localparam int MBX_EN_BIT = 1;
  localparam logic [2:0] BP_MODE_LAST = 3'h4;

  // Host TMS walks, sent LSB first
  localparam logic [7:0] TMS_RESET = 8'h1F;
  localparam logic [3:0] TMS_RESET_N = 4'h6;
  localparam logic [7:0] TMS_TO_SHIR = 8'h03;
  localparam logic [3:0] TMS_TO_SHIR_N = 4'h4;
  localparam logic [7:0] TMS_TO_SHDR = 8'h01;
  localparam logic [3:0] TMS_TO_SHDR_N = 4'h3;
  localparam logic [7:0] TMS_TO_RTI = 8'h01;
  localparam logic [3:0] TMS_TO_RTI_N = 4'h2;
  localparam logic [5:0] HOST_LEN_MAX = 6'h20;

  // Host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TXD = 8'h04;
  localparam logic [7:0] REG_RXD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_LEN_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RST_LOW_BIT = 1;
  localparam int CTRL_RST_BIT = 0;

endpackage

//--- src/tap_link_if.sv
// Four TAP wires plus the shared open-collector system reset line.
// The reset line idles high; either end may only pull it low.
`timescale 1ns/100ps
`default_nettype none
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic host_rst_out;
  logic host_rst_oe_n;
  logic dev_rst_out;
  logic dev_rst_oe_n;
  logic rst_level;

  assign rst_level = !(!host_rst_oe_n && !host_rst_out) && !(!dev_rst_oe_n && !dev_rst_out);

  modport device (input tck, input tms, input tdi, output tdo,
                  output dev_rst_out, output dev_rst_oe_n, input rst_level);
  modport host (output tck, output tms, output tdi, input tdo,
                output host_rst_out, output host_rst_oe_n, input rst_level);
endinterface
`default_nettype wire

//--- src/tap_debug_device.sv
// Device end: TAP controller, debug data registers and CPU byte mailbox.
// TCK, TMS, TDI and the reset line are sampled on i_clock, which must run
// several times faster than TCK; fuses and CPU strobes are i_clock logic.
// Behaviour
// R1: unprogrammed tap fuse: port pins, TAP reset
// R2: fuse set, disable clear: pull-ups, JTAG on
// R3: no TRST; reset only by power-on, TMS
// R4: sixteen-state controller stepped by TMS at TCK rise
// R5: controller starts in Test-Logic-Reset after reset
// R6: all shift registers shift LSB first
// R7: host walks 1,1,0,0 into Shift-IR
// R8: instruction capture value 0x01 shifted out
// R9: host raises TMS on fourth instruction bit
// R10: instruction output changes only in Update-IR; the code also loads BYPASS in Test-Logic-Reset and while the TAP is disabled
// R11: host walks 1,0,0 into Shift-DR
// R12: Shift-DR outputs the Capture-DR parallel value
// R13: latched data outputs change only in Update-DR
// R14: five TMS-high periods always reach Test-Logic-Reset
// R15: opcodes 0x8 to 0xB reach debug system
// R16: debug needs fuse and no lock bit
// R17: four break points, five layouts
// R18: CPU mailbox write sets dirty flag
// R19: CPU read returns dirty plus seven bits
// R20: debugger clears dirty flag after reading
// R21: shared address routed to mailbox only when enabled
// R22: host watches and may pull reset line
// R23: reset clears mailbox and dirty flag
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tap_debug_device
  import jtag_pkg::*;
#(
  parameter bit SHARED_IO = 1'b1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // TAP link
  tap_link_if.device link,
  // Fuses and lock bits
  input wire logic i_tap_enable_fuse,
  input wire logic i_tap_disable_bit,
  input wire logic i_debug_enable_fuse,
  input wire logic i_lock_bit_one,
  input wire logic i_lock_bit_two,
  // CPU access to the shared mailbox address
  input wire logic i_cpu_sel,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [MBX_W-1:0] i_cpu_wdata,
  output logic [MBX_W-1:0] o_cpu_rdata,
  output logic o_io_wr,
  output logic o_io_rd,
  // System reset line
  input wire logic i_reset_req,
  output logic o_reset_seen,
  // Debug status and control
  output logic o_port_mode,
  output logic o_pullup_en,
  output logic o_debug_active,
  output logic [IR_W-1:0] o_instruction,
  output bp_mode_t o_bp_mode,
  output logic [7:0] o_debug_cmd,
  output logic o_debug_cmd_stb,
  output logic o_mbx_dirty
);

  typedef struct packed {
    logic [1:0] tck_ff;
    logic [1:0] tms_ff;
    logic [1:0] tdi_ff;
    logic [1:0] rst_ff;
    logic tck_last;
    tap_state_t state;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] ir;
    logic [DR_MAX-1:0] dr_sr;
    logic tdo;
    logic [MBX_W-1:0] mbx;
    logic dirty;
    logic mbx_en;
    bp_mode_t bp_mode;
    logic [7:0] cmd;
    logic cmd_stb;
    logic [MBX_W-1:0] rdata;
    logic io_wr;
    logic io_rd;
    logic rst_oe_n;
  } dev_state_t;

  localparam dev_state_t RESET_STATE = '{
    tck_ff: 2'h0, tms_ff: 2'h3, tdi_ff: 2'h3, rst_ff: 2'h3, tck_last: 1'b0,
    state: TLR, ir_sr: IR_CAPTURE, ir: IR_BYPASS, dr_sr: '0, tdo: 1'b0,
    mbx: '0, dirty: 1'b0, mbx_en: 1'b0, bp_mode: BP_4PROG, cmd: 8'h00,
    cmd_stb: 1'b0, rdata: '0, io_wr: 1'b0, io_rd: 1'b0, rst_oe_n: 1'b1
  };

  dev_state_t r_reg;
  dev_state_t r_next;

  logic tap_on;
  logic debug_ok;
  logic tck_rise;
  logic tck_fall;
  logic mbx_hit;

  function automatic tap_state_t step(input tap_state_t s, input logic tms);
    case (s)
      TLR: step = tms ? TLR : RTI;
      RTI: step = tms ? SEL_DR : RTI;
      SEL_DR: step = tms ? SEL_IR : CAP_DR;
      CAP_DR: step = tms ? EX1_DR : SH_DR;
      SH_DR: step = tms ? EX1_DR : SH_DR;
      EX1_DR: step = tms ? UPD_DR : PAU_DR;
      PAU_DR: step = tms ? EX2_DR : PAU_DR;
      EX2_DR: step = tms ? UPD_DR : SH_DR;
      UPD_DR: step = tms ? SEL_DR : RTI;
      SEL_IR: step = tms ? TLR : CAP_IR;
      CAP_IR: step = tms ? EX1_IR : SH_IR;
      SH_IR: step = tms ? EX1_IR : SH_IR;
      EX1_IR: step = tms ? UPD_IR : PAU_IR;
      PAU_IR: step = tms ? EX2_IR : PAU_IR;
      EX2_IR: step = tms ? UPD_IR : SH_IR;
      UPD_IR: step = tms ? SEL_DR : RTI;
      default: step = TLR;
    endcase
  endfunction

  // Private opcodes only select their registers while debug is allowed
  function automatic logic [3:0] dr_len(input logic [IR_W-1:0] ir, input logic ok);
    dr_len = LEN_ONE;
    if (ok && ir == OP_DEBUG0) begin
      dr_len = LEN_MBX;
    end else if (ok && ir == OP_DEBUG1) begin
      dr_len = LEN_BP;
    end else if (ok && ir == OP_DEBUG2) begin
      dr_len = LEN_CMD;
    end
  endfunction

  assign tap_on = i_tap_enable_fuse && !i_tap_disable_bit;  // [R1] [R2]
  assign debug_ok = tap_on && i_debug_enable_fuse && !i_lock_bit_one && !i_lock_bit_two;  // [R16]
  assign tck_rise = r_reg.tck_ff[1] && !r_reg.tck_last;
  assign tck_fall = !r_reg.tck_ff[1] && r_reg.tck_last;
  assign mbx_hit = i_cpu_sel && (!SHARED_IO || (debug_ok && r_reg.mbx_en));  // [R21]

  always_comb begin
    logic [DR_MAX-1:0] sh;
    logic [3:0] len;
    sh = '0;
    len = dr_len(r_reg.ir, debug_ok);
    r_next = r_reg;
    r_next.tck_ff = {r_reg.tck_ff[0], link.tck};
    r_next.tms_ff = {r_reg.tms_ff[0], link.tms};
    r_next.tdi_ff = {r_reg.tdi_ff[0], link.tdi};
    r_next.rst_ff = {r_reg.rst_ff[0], link.rst_level};
    r_next.tck_last = r_reg.tck_ff[1];
    r_next.cmd_stb = 1'b0;
    r_next.io_wr = 1'b0;
    r_next.io_rd = 1'b0;
    r_next.rst_oe_n = !i_reset_req;
    if (tck_rise) begin
      r_next.state = step(r_reg.state, r_reg.tms_ff[1]);  // [R4] [R14]
      case (r_reg.state)
        CAP_IR: begin
          r_next.ir_sr = IR_CAPTURE;  // [R8]
        end
        SH_IR: begin
          r_next.ir_sr = {r_reg.tdi_ff[1], r_reg.ir_sr[IR_W-1:1]};  // [R6]
        end
        UPD_IR: begin
          r_next.ir = r_reg.ir_sr;  // [R10] [R15]
        end
        CAP_DR: begin
          r_next.dr_sr = '0;  // [R12]
          if (debug_ok && r_reg.ir == OP_DEBUG0) begin
            r_next.dr_sr = {r_reg.dirty, r_reg.mbx};
          end else if (debug_ok && r_reg.ir == OP_DEBUG1) begin
            r_next.dr_sr[2:0] = r_reg.bp_mode;
          end else if (debug_ok && r_reg.ir == OP_DEBUG2) begin
            r_next.dr_sr[7:0] = r_reg.cmd;
          end else if (debug_ok && r_reg.ir == OP_DEBUG3) begin
            r_next.dr_sr[0] = r_reg.dirty;
          end
        end
        SH_DR: begin
          sh = r_reg.dr_sr >> 1;
          sh[len - 4'h1] = r_reg.tdi_ff[1];  // [R6]
          r_next.dr_sr = sh;
        end
        UPD_DR: begin
          if (debug_ok && r_reg.ir == OP_DEBUG0) begin  // [R13]
            r_next.mbx_en = r_reg.dr_sr[MBX_EN_BIT];
            if (r_reg.dr_sr[MBX_CLR_BIT]) begin
              r_next.dirty = 1'b0;  // [R20]
            end
          end else if (debug_ok && r_reg.ir == OP_DEBUG1) begin
            if (r_reg.dr_sr[2:0] <= BP_MODE_LAST) begin
              r_next.bp_mode = bp_mode_t'(r_reg.dr_sr[2:0]);  // [R17]
            end
          end else if (debug_ok && r_reg.ir == OP_DEBUG2) begin
            r_next.cmd = r_reg.dr_sr[7:0];
            r_next.cmd_stb = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // TDO moves on the falling edge so the host can sample it at the end of the next high phase, as TCK next falls
    if (tck_fall) begin
      if (r_reg.state == SH_IR) begin
        r_next.tdo = r_reg.ir_sr[0];  // [R6] [R8]
      end else if (r_reg.state == SH_DR) begin
        r_next.tdo = r_reg.dr_sr[0];  // [R12]
      end
    end
    if (r_reg.state == TLR) begin
      r_next.ir = IR_BYPASS;
    end
    if (!tap_on) begin
      r_next.state = TLR;  // [R1]
      r_next.ir = IR_BYPASS;
    end
    if (!debug_ok) begin
      r_next.mbx_en = 1'b0;  // [R16]
    end
    if (i_cpu_sel && !mbx_hit) begin
      r_next.io_wr = i_cpu_wr;  // [R21]
      r_next.io_rd = i_cpu_rd;
    end
    if (mbx_hit && i_cpu_rd) begin
      r_next.rdata = {r_reg.dirty, r_reg.mbx[MBX_W-2:0]};  // [R19]
    end
    // A CPU write beats a clear from the debugger in the same cycle
    if (mbx_hit && i_cpu_wr) begin
      r_next.mbx = i_cpu_wdata;
      r_next.dirty = 1'b1;  // [R18]
    end
  end

  // Only the system reset, a TMS walk and a disabled TAP (tap_on low) reset the TAP; there is no TRST pin
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      r_reg <= RESET_STATE;  // [R3] [R5] [R23]
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.tdo = r_reg.tdo;
  assign link.dev_rst_out = 1'b0;
  assign link.dev_rst_oe_n = r_reg.rst_oe_n;
  assign o_cpu_rdata = r_reg.rdata;
  assign o_io_wr = r_reg.io_wr;
  assign o_io_rd = r_reg.io_rd;
  assign o_reset_seen = !r_reg.rst_ff[1];
  assign o_port_mode = !i_tap_enable_fuse;  // [R1]
  assign o_pullup_en = tap_on;  // [R2]
  assign o_debug_active = debug_ok;
  assign o_instruction = r_reg.ir;
  assign o_bp_mode = r_reg.bp_mode;
  assign o_debug_cmd = r_reg.cmd;
  assign o_debug_cmd_stb = r_reg.cmd_stb;
  assign o_mbx_dirty = r_reg.dirty;

endmodule
`default_nettype wire

//--- src/tap_debug_host.sv
// Host end: APB-programmed TAP master that walks TMS and shifts IR or DR.
// TCK is divided from i_clock; TDO and the reset line are synchronised.
// IR and DR walks assume the device starts in Run-Test/Idle, so issue a reset walk first.
`timescale 1ns/100ps
`default_nettype none
module tap_debug_host
  import jtag_pkg::*;
#(
  parameter int HALF_PERIOD = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // TAP link
  tap_link_if.host link
);

  // Device needs about four clocks to see each TCK edge
  if (HALF_PERIOD < 4 || HALF_PERIOD > 255) begin : g_half_check
    $error("HALF_PERIOD out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_PERIOD - 1);

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic rst_drive;
    logic [7:0] cnt;
    host_state_t hstate;
    host_kind_t kind;
    logic [7:0] seq;
    logic [3:0] seq_n;
    logic [5:0] idx;
    logic [5:0] len;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] prdata;
    logic [1:0] tdo_ff;
    logic [1:0] rst_ff;
  } host_regs_t;

  host_regs_t r_reg;
  host_regs_t r_next;

  logic setup;
  logic access;
  logic mapped;
  logic [5:0] cmd_len;
  host_kind_t cmd_kind;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign mapped = i_paddr == REG_CMD || i_paddr == REG_TXD || i_paddr == REG_RXD ||
                  i_paddr == REG_STAT || i_paddr == REG_CTRL;
  assign cmd_len = i_pwdata[CMD_LEN_LSB +: 6];
  assign cmd_kind = host_kind_t'(i_pwdata[CMD_KIND_LSB +: 2]);

  always_comb begin
    r_next = r_reg;
    r_next.tdo_ff = {r_reg.tdo_ff[0], link.tdo};
    r_next.rst_ff = {r_reg.rst_ff[0], link.rst_level};  // [R22]
    if (setup) begin
      r_next.prdata = 32'h0000_0000;
      if (i_paddr == REG_TXD) begin
        r_next.prdata = r_reg.tx;
      end else if (i_paddr == REG_RXD) begin
        r_next.prdata = r_reg.rx;
      end else if (i_paddr == REG_STAT) begin
        r_next.prdata[STAT_BUSY_BIT] = r_reg.hstate != H_IDLE;
        r_next.prdata[STAT_RST_LOW_BIT] = !r_reg.rst_ff[1];
      end else if (i_paddr == REG_CTRL) begin
        r_next.prdata[CTRL_RST_BIT] = r_reg.rst_drive;
      end
    end
    if (access && i_pwrite) begin
      if (i_paddr == REG_TXD) begin
        r_next.tx = i_pwdata;
      end else if (i_paddr == REG_CTRL) begin
        r_next.rst_drive = i_pwdata[CTRL_RST_BIT];  // [R22]
      end else if (i_paddr == REG_CMD && r_reg.hstate == H_IDLE) begin
        r_next.kind = cmd_kind;
        r_next.len = cmd_len;
        r_next.idx = 6'h00;
        r_next.rx = 32'h0000_0000;
        r_next.cnt = 8'h00;
        r_next.tck = 1'b0;
        if (cmd_kind == KIND_RESET) begin
          r_next.seq = TMS_RESET;  // [R14]
          r_next.seq_n = TMS_RESET_N;
          r_next.hstate = H_PRE;
        end else if (cmd_kind == KIND_IR) begin
          r_next.seq = TMS_TO_SHIR;  // [R7]
          r_next.seq_n = TMS_TO_SHIR_N;
          r_next.len = 6'(IR_W);
          r_next.hstate = H_PRE;
        end else if (cmd_kind == KIND_DR && cmd_len != 6'h00 && cmd_len <= HOST_LEN_MAX) begin
          r_next.seq = TMS_TO_SHDR;  // [R11]
          r_next.seq_n = TMS_TO_SHDR_N;
          r_next.hstate = H_PRE;
        end
        r_next.tms = r_next.seq[0];
      end
    end
    if (r_reg.hstate != H_IDLE) begin
      r_next.cnt = r_reg.cnt + 8'h01;
      if (r_reg.cnt == HALF_LAST) begin
        r_next.cnt = 8'h00;
        if (!r_reg.tck) begin
          r_next.tck = 1'b1;
        end else begin
          // End of one TCK period: TDO still holds the bit of the rise just done
          r_next.tck = 1'b0;
          case (r_reg.hstate)
            H_PRE: begin
              r_next.seq = r_reg.seq >> 1;
              r_next.seq_n = r_reg.seq_n - 4'h1;
              if (r_reg.seq_n == 4'h1) begin
                r_next.hstate = r_reg.kind == KIND_RESET ? H_IDLE : H_SHIFT;
              end
            end
            H_SHIFT: begin
              r_next.rx[r_reg.idx[4:0]] = r_reg.tdo_ff[1];  // [R6]
              r_next.idx = r_reg.idx + 6'h01;
              if (r_reg.idx == r_reg.len - 6'h01) begin
                r_next.hstate = H_POST;
                r_next.seq = TMS_TO_RTI;  // [R10]
                r_next.seq_n = TMS_TO_RTI_N;
              end
            end
            H_POST: begin
              r_next.seq = r_reg.seq >> 1;
              r_next.seq_n = r_reg.seq_n - 4'h1;
              if (r_reg.seq_n == 4'h1) begin
                r_next.hstate = H_IDLE;
              end
            end
            default: begin
            end
          endcase
          r_next.tms = 1'b0;
          if (r_next.hstate == H_SHIFT) begin
            r_next.tms = r_next.idx == r_reg.len - 6'h01;  // [R9]
            r_next.tdi = r_reg.tx[r_next.idx[4:0]];  // [R6]
          end else if (r_next.hstate != H_IDLE) begin
            r_next.tms = r_next.seq[0];
          end
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      r_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, rst_drive: 1'b0, cnt: 8'h00, hstate: H_IDLE,
                 kind: KIND_RESET, seq: 8'h00, seq_n: 4'h0, idx: 6'h00, len: 6'h00,
                 tx: 32'h0000_0000, rx: 32'h0000_0000, prdata: 32'h0000_0000,
                 tdo_ff: 2'h0, rst_ff: 2'h3};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_prdata = r_reg.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;
  assign link.tck = r_reg.tck;
  assign link.tms = r_reg.tms;
  assign link.tdi = r_reg.tdi;
  assign link.host_rst_out = 1'b0;
  assign link.host_rst_oe_n = !r_reg.rst_drive;  // [R22]

endmodule
`default_nettype wire

//--- testbench/jtag_tap_debug_channel_sva.sv
// Checker on the TAP link wires and the shared reset line.
// Assumes the host is built with a TCK half period of eight clocks.
`timescale 1ns/100ps
`default_nettype none
module jtag_tap_debug_channel_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Link wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic host_rst_out,
  input wire logic host_rst_oe_n,
  input wire logic dev_rst_out,
  input wire logic dev_rst_oe_n,
  input wire logic rst_level
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  a_reset_idle: assert property ($fell(i_srst) |-> host_rst_oe_n && dev_rst_oe_n && !tck && tms)
    else $error("link not idle after reset");
  a_only_pull_low: assert property (!host_rst_out && !dev_rst_out)
    else $error("reset line driven high");
  a_line_pulled: assert property ((!host_rst_oe_n || !dev_rst_oe_n) |-> !rst_level)
    else $error("pulled reset line not low");
  a_line_free: assert property ((host_rst_oe_n && dev_rst_oe_n) |-> rst_level)
    else $error("released reset line not high");
  // Both host outputs must settle while TCK is low so the device samples a stable level
  a_tms_low_phase: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck high");
  a_tdi_low_phase: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck high");
  a_tck_high_len: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
    else $error("tck high phase length wrong");
  a_tck_low_len: assert property ($fell(tck) |-> !tck [*8])
    else $error("tck low phase too short");
  a_tdo_low_phase: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");

  c_tck_run: cover property ($rose(tck));
  c_tdo_move: cover property ($changed(tdo));
  c_line_pull: cover property ($fell(rst_level));
endmodule
`default_nettype wire

//--- testbench/jtag_tap_debug_channel_tb_top.sv
// Top bench: host and device joined by the link, APB and CPU driven here.
// Assumes the package, the link interface and both ends compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %0t: got %h want %h", $time, (g), (e)); end end
module jtag_tap_debug_channel_tb_top;
  import jtag_pkg::*;
  typedef struct packed {
    logic [3:0] op;
    logic [5:0] len;
    logic [8:0] txd;
    logic [8:0] mask;
    logic [8:0] cap;
    logic [2:0] bp;
    logic [7:0] cmd;
  } row_t;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, cwdata = 8'h00, crdata, dcmd;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, io_wr, io_rd, rseen, pmode, pull, dact, cstb, dirty;
  logic tfuse = 1'b1, tdis = 1'b0, dfuse = 1'b1, lock1 = 1'b0, lock2 = 1'b0;
  logic csel = 1'b0, cwr = 1'b0, crd = 1'b0, rreq = 1'b0;
  logic [3:0] instr;
  bp_mode_t bpm;
  int checks = 0, fail_count = 0, io_wr_cnt = 0, io_rd_cnt = 0, stb_cnt = 0;
  // Bit 1 of the mailbox row leaves CPU access routed to the mailbox
  row_t rows [11] = '{
    '{OP_DEBUG2, 6'h08, 9'h0A5, 9'h0FF, 9'h000, 3'h0, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h001, 9'h007, 9'h000, 3'h1, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h002, 9'h007, 9'h001, 3'h2, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h003, 9'h007, 9'h002, 3'h3, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h004, 9'h007, 9'h003, 3'h4, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h005, 9'h007, 9'h004, 3'h4, 8'hA5},
    '{OP_DEBUG1, 6'h03, 9'h000, 9'h007, 9'h004, 3'h0, 8'hA5},
    '{OP_DEBUG3, 6'h01, 9'h001, 9'h001, 9'h000, 3'h0, 8'hA5},
    '{4'h5, 6'h01, 9'h001, 9'h001, 9'h000, 3'h0, 8'hA5},
    '{4'hF, 6'h01, 9'h001, 9'h001, 9'h000, 3'h0, 8'hA5},
    '{OP_DEBUG0, 6'h09, 9'h002, 9'h1FF, 9'h000, 3'h0, 8'hA5}};

  tap_link_if link ();
  tap_debug_host #(.HALF_PERIOD(8)) tap_debug_host_inst (.i_clock(clk), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link));
  tap_debug_device tap_debug_device_inst (.i_clock(clk), .i_srst(srst), .link(link),
    .i_tap_enable_fuse(tfuse), .i_tap_disable_bit(tdis), .i_debug_enable_fuse(dfuse),
    .i_lock_bit_one(lock1), .i_lock_bit_two(lock2), .i_cpu_sel(csel), .i_cpu_wr(cwr), .i_cpu_rd(crd),
    .i_cpu_wdata(cwdata), .o_cpu_rdata(crdata), .o_io_wr(io_wr), .o_io_rd(io_rd), .i_reset_req(rreq),
    .o_reset_seen(rseen), .o_port_mode(pmode), .o_pullup_en(pull), .o_debug_active(dact),
    .o_instruction(instr), .o_bp_mode(bpm), .o_debug_cmd(dcmd), .o_debug_cmd_stb(cstb), .o_mbx_dirty(dirty));
  jtag_tap_debug_channel_sva jtag_tap_debug_channel_sva_inst (.i_clock(clk), .i_srst(srst),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .host_rst_out(link.host_rst_out),
    .host_rst_oe_n(link.host_rst_oe_n), .dev_rst_out(link.dev_rst_out),
    .dev_rst_oe_n(link.dev_rst_oe_n), .rst_level(link.rst_level));

  always #12.5 clk = ~clk;
  // Single-cycle pulses are counted so later checks cannot miss them
  always @(posedge clk) begin
    if (io_wr === 1'b1) io_wr_cnt++;
    if (io_rd === 1'b1) io_rd_cnt++;
    if (cstb === 1'b1) stb_cnt++;
  end

  // Waits for pready as long as it takes; only the watchdog ends a hung transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic walk(input logic [1:0] k, input logic [5:0] len, input logic [31:0] d);
    apb(1'b1, REG_TXD, d);
    apb(1'b1, REG_CMD, {18'h0, len, 6'h0, k});
    do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    apb(1'b0, REG_RXD, 32'h0);
  endtask

  task automatic ir(input logic [3:0] op);
    walk(KIND_IR, 6'h00, {28'h0, op});
    `CHECK(rd[3:0], IR_CAPTURE)
    `CHECK(instr, op)
  endtask

  task automatic cpu(input logic w, input logic [7:0] d);
    @(posedge clk);
    csel <= 1'b1; cwr <= w; crd <= !w; cwdata <= d;
    @(posedge clk);
    csel <= 1'b0; cwr <= 1'b0; crd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic settle(input logic [3:0] exp_instr);
    repeat (3) @(posedge clk);
    `CHECK(instr, exp_instr)
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    fail_count++;
    $display("unexpected %0t: run hung", $time);
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHECK(instr, IR_BYPASS)
    `CHECK(dirty, 1'b0)
    `CHECK({pmode, pull}, 2'b01)
    walk(KIND_RESET, 6'h00, 32'h0);
    foreach (rows[i]) begin
      ir(rows[i].op);
      walk(KIND_DR, rows[i].len, {23'h0, rows[i].txd});
      `CHECK(rd[8:0] & rows[i].mask, rows[i].cap)
      `CHECK(bpm, rows[i].bp)
      `CHECK(dcmd, rows[i].cmd)
    end
    `CHECK(stb_cnt, 1)
    done("table");
    cpu(1'b1, 8'h5A);
    `CHECK(dirty, 1'b1)
    `CHECK(io_wr_cnt, 0)
    cpu(1'b0, 8'h00);
    `CHECK(crdata, 8'hDA)
    ir(OP_DEBUG0);
    walk(KIND_DR, 6'h09, 32'h3);
    `CHECK(rd[8:0], 9'h15A)
    `CHECK(dirty, 1'b0)
    walk(KIND_DR, 6'h09, 32'h0);
    cpu(1'b1, 8'h33);
    `CHECK(io_wr_cnt, 1)
    `CHECK(dirty, 1'b0)
    cpu(1'b0, 8'h00);
    `CHECK(io_rd_cnt, 1)
    `CHECK(crdata, 8'hDA)
    done("mailbox");
    lock1 <= 1'b1;
    ir(OP_DEBUG2);
    walk(KIND_DR, 6'h08, 32'h3C);
    `CHECK(dcmd, 8'hA5)
    `CHECK(dact, 1'b0)
    lock1 <= 1'b0;
    lock2 <= 1'b1;
    settle(OP_DEBUG2);
    `CHECK(dact, 1'b0)
    lock2 <= 1'b0;
    dfuse <= 1'b0;
    settle(OP_DEBUG2);
    `CHECK(dact, 1'b0)
    dfuse <= 1'b1;
    settle(OP_DEBUG2);
    `CHECK(dact, 1'b1)
    done("locks");
    tfuse <= 1'b0;
    settle(IR_BYPASS);
    `CHECK({pmode, pull}, 2'b10)
    tfuse <= 1'b1;
    tdis <= 1'b1;
    settle(IR_BYPASS);
    `CHECK({pmode, pull}, 2'b00)
    tdis <= 1'b0;
    walk(KIND_RESET, 6'h00, 32'h0);
    ir(4'h5);
    walk(KIND_RESET, 6'h00, 32'h0);
    `CHECK(instr, IR_BYPASS)
    done("enables");
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    `CHECK(rseen, 1'b1)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHECK(rd[CTRL_RST_BIT], 1'b1)
    apb(1'b1, REG_CTRL, 32'h0);
    rreq <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    `CHECK(rd[STAT_RST_LOW_BIT], 1'b1)
    rreq <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    `CHECK({rd[STAT_RST_LOW_BIT], rseen}, 2'b00)
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    `CHECK(err, 1'b1)
    apb(1'b0, 8'h14, 32'h0);
    `CHECK({err, rd}, {1'b1, 32'h0})
    done("reset line and bus");
    ir(OP_DEBUG0);
    walk(KIND_DR, 6'h09, 32'h2);
    cpu(1'b1, 8'h77);
    `CHECK(dirty, 1'b1)
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHECK(dirty, 1'b0)
    `CHECK(instr, IR_BYPASS)
    walk(KIND_RESET, 6'h00, 32'h0);
    ir(OP_DEBUG0);
    walk(KIND_DR, 6'h09, 32'h2);
    `CHECK(rd[8:0], 9'h000)
    done("mid-run reset");
    give_verdict();
  end
endmodule
`default_nettype wire
